/* File: rtl/sdr_pkg.sv */
// Purpose: Shared constants, field layouts and code tables for the speed detect and reverse drive settings bank.
// Assumes: 100 MHz hclk; registers reached over AHB-Lite with 32-bit data.
// Notes:   Register indices are byte address divided by four.
package sdr_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_NS          = 1000000;
    localparam int MS_TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int COAST_MS_W     = 14;

    // ========================================================================
    // Register map (index, byte address = index * 4)
    // ========================================================================
    localparam logic [9:0]  IDX_STARTUP  = 10'h080;
    localparam logic [9:0]  IDX_REVERSAL = 10'h082;
    localparam logic [9:0]  IDX_STATUS   = 10'h0a0;
    localparam logic [11:0] ADDR_STARTUP  = {IDX_STARTUP, 2'b00};
    localparam logic [11:0] ADDR_REVERSAL = {IDX_REVERSAL, 2'b00};
    localparam logic [11:0] ADDR_STATUS   = {IDX_STATUS, 2'b00};
    localparam logic [31:0] RST_STARTUP  = 32'h0000_0000;
    localparam logic [31:0] RST_REVERSAL = 32'h0000_0000;

    // ========================================================================
    // Startup speed detect field positions
    // ========================================================================
    localparam int SSD_COAST_ON  = 28;
    localparam int SSD_REV_ON    = 27;
    localparam int SSD_COAST_HI  = 12;
    localparam int SSD_COAST_LO  = 9;
    localparam int SSD_BEMF_HI   = 8;
    localparam int SSD_BEMF_LO   = 6;
    localparam int SSD_SPEED_HI  = 5;
    localparam int SSD_SPEED_LO  = 2;
    localparam int SSD_ILIM_HI   = 1;
    localparam int SSD_ILIM_LO   = 0;

    // ========================================================================
    // Reversal drive field positions
    // ========================================================================
    localparam int RDS_PARITY   = 31;
    localparam int RDS_COEF1_HI = 30;
    localparam int RDS_COEF1_LO = 27;
    localparam int RDS_COEF2_HI = 26;
    localparam int RDS_COEF2_LO = 23;
    localparam int RDS_BRKI_HI  = 22;
    localparam int RDS_BRKI_LO  = 20;
    localparam int RDS_KP_HI    = 19;
    localparam int RDS_KP_LO    = 10;
    localparam int RDS_KI_HI    = 9;
    localparam int RDS_KI_LO    = 0;

    // Status bit positions.
    localparam int STS_COAST     = 0;
    localparam int STS_STANDSTILL = 1;
    localparam int STS_HANDOFF   = 2;

    // ========================================================================
    // Code tables
    // ========================================================================
    // Standstill back-EMF level in mV.
    function automatic logic [10:0] sdr_bemf_mv(input logic [2:0] code);
        case (code)
            3'h0:    sdr_bemf_mv = 11'd50;
            3'h1:    sdr_bemf_mv = 11'd75;
            3'h2:    sdr_bemf_mv = 11'd100;
            3'h3:    sdr_bemf_mv = 11'd250;
            3'h4:    sdr_bemf_mv = 11'd500;
            3'h5:    sdr_bemf_mv = 11'd750;
            3'h6:    sdr_bemf_mv = 11'd1000;
            default: sdr_bemf_mv = 11'd1500;
        endcase
    endfunction : sdr_bemf_mv

    // Hand-off speed in tenths of a percent of maximum speed.
    function automatic logic [9:0] sdr_speed_pm(input logic [3:0] code);
        case (code)
            4'h0:    sdr_speed_pm = 10'd25;
            4'h1:    sdr_speed_pm = 10'd50;
            4'h2:    sdr_speed_pm = 10'd75;
            4'h3:    sdr_speed_pm = 10'd100;
            4'h4:    sdr_speed_pm = 10'd125;
            4'h5:    sdr_speed_pm = 10'd150;
            4'h6:    sdr_speed_pm = 10'd200;
            4'h7:    sdr_speed_pm = 10'd250;
            4'h8:    sdr_speed_pm = 10'd300;
            4'h9:    sdr_speed_pm = 10'd400;
            4'ha:    sdr_speed_pm = 10'd500;
            4'hb:    sdr_speed_pm = 10'd600;
            4'hc:    sdr_speed_pm = 10'd700;
            4'hd:    sdr_speed_pm = 10'd800;
            4'he:    sdr_speed_pm = 10'd900;
            default: sdr_speed_pm = 10'd1000;
        endcase
    endfunction : sdr_speed_pm

    // Open-loop reversal current limit in mA.
    function automatic logic [12:0] sdr_ilimit_ma(input logic [1:0] code);
        case (code)
            2'h0:    sdr_ilimit_ma = 13'd1500;
            2'h1:    sdr_ilimit_ma = 13'd2500;
            2'h2:    sdr_ilimit_ma = 13'd3500;
            default: sdr_ilimit_ma = 13'd5000;
        endcase
    endfunction : sdr_ilimit_ma

    // Coast duration in ms.
    function automatic logic [COAST_MS_W-1:0] sdr_coast_ms(input logic [3:0] code);
        case (code)
            4'h0:    sdr_coast_ms = 14'd10;
            4'h1:    sdr_coast_ms = 14'd50;
            4'h2:    sdr_coast_ms = 14'd100;
            4'h3:    sdr_coast_ms = 14'd200;
            4'h4:    sdr_coast_ms = 14'd300;
            4'h5:    sdr_coast_ms = 14'd400;
            4'h6:    sdr_coast_ms = 14'd500;
            4'h7:    sdr_coast_ms = 14'd750;
            4'h8:    sdr_coast_ms = 14'd1000;
            4'h9:    sdr_coast_ms = 14'd2000;
            4'ha:    sdr_coast_ms = 14'd3000;
            4'hb:    sdr_coast_ms = 14'd4000;
            4'hc:    sdr_coast_ms = 14'd5000;
            4'hd:    sdr_coast_ms = 14'd7500;
            4'he:    sdr_coast_ms = 14'd10000;
            default: sdr_coast_ms = 14'd15000;
        endcase
    endfunction : sdr_coast_ms

endpackage : sdr_pkg

/* File: rtl/sdr_coast_timer.sv */
// Purpose: Times the high-impedance coast interval in whole milliseconds.
// Assumes: One clock; the millisecond rate is an enable pulse from a prescaler.
// Notes:   The prescaler restarts on each start so the first interval is full length.
`timescale 1ns/1ps
module sdr_coast_timer #(
    parameter int TICK_CYCLES = sdr_pkg::MS_TICK_CYCLES
) (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          start,
    input  wire logic                          abort,
    input  wire logic [sdr_pkg::COAST_MS_W-1:0] dur_ms,
    output logic                               active
);

    generate
        if (TICK_CYCLES < 2 || TICK_CYCLES > 1048576) begin : g_bad_tick
            $error("sdr_coast_timer: TICK_CYCLES out of range");
        end
    endgenerate

    typedef struct packed {
        logic                          active;
        logic [19:0]                   pre;
        logic [sdr_pkg::COAST_MS_W-1:0] ms_left;
    } sdr_ct_state_t;

    sdr_ct_state_t s_r;
    sdr_ct_state_t s_nxt;

    // ========================================================================
    // Next state
    // ========================================================================
    // Abort wins over start so a disabled coast step never re-arms itself.
    always_comb begin
        s_nxt = s_r;
        if (abort) begin
            s_nxt = '0;
        end else if (start && !s_r.active) begin
            s_nxt.active  = 1'b1;
            s_nxt.pre     = 20'(TICK_CYCLES - 1);
            s_nxt.ms_left = dur_ms;
        end else if (s_r.active) begin
            if (s_r.pre != 20'h0) begin
                s_nxt.pre = s_r.pre - 20'h1;
            end else begin
                s_nxt.pre = 20'(TICK_CYCLES - 1);
                if (s_r.ms_left <= 14'h1) begin
                    s_nxt.active  = 1'b0;
                    s_nxt.ms_left = '0;
                end else begin
                    s_nxt.ms_left = s_r.ms_left - 14'h1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign active = s_r.active;

endmodule : sdr_coast_timer

/* File: rtl/sdr_settings_bank.sv */
// Purpose: AHB-Lite register bank for startup speed detect and reversal drive settings, with live comparators.
// Assumes: Zero-wait slave; word transfers only; other sizes are handled as words.
// Notes:   Decoded fields leave the block as registered outputs for the control algorithm.
//
// Overview of operation
// RULE_01: Motor counts as standstill while back-EMF is under the 3-bit selected level.
// RULE_02: Reversal decel hands off to open loop at or below the selected speed.
// RULE_03: Open-loop reversal current limit follows a 2-bit code, 1.5 to 5.0 A.
// RULE_04: Reversal drive settings register sits at index 82h and resets to zero.
// RULE_05: Reversal register holds parity, two coefficients, brake limit, Kp and Ki fields.
// RULE_06: Outputs coast in high impedance for the 4-bit selected duration, 10 ms to 15 s.
// RULE_07: Bit 27 of the startup register enables reverse drive.
// RULE_08: Bit 28 of the startup register enables the coast step.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module sdr_settings_bank #(
    parameter int MS_TICK_CYCLES = sdr_pkg::MS_TICK_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [10:0] bemf_mv,
    input  wire logic [9:0]  speed_permille,
    input  wire logic        reversal_decel,
    input  wire logic        coast_request,
    output logic             motor_standstill,
    output logic             open_loop_handoff,
    output logic [12:0]      reversal_openloop_ilimit,
    output logic             coast_active,
    output logic             reversal_drive_on,
    output logic             coast_step_on,
    output logic [3:0]       reversal_ramp_coef_one,
    output logic [3:0]       reversal_ramp_coef_two,
    output logic [2:0]       braking_ilimit_sel,
    output logic [9:0]       braking_prop_gain,
    output logic [9:0]       braking_integ_gain,
    output logic             reversal_parity
);

    generate
        if (MS_TICK_CYCLES < 2) begin : g_bad_tick
            $error("sdr_settings_bank: MS_TICK_CYCLES too small");
        end
    endgenerate

    typedef struct packed {
        logic        hready;
        logic        wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        logic [31:0] startup;
        logic [31:0] reversal;
        logic        standstill;
        logic        handoff;
        logic [12:0] ilimit_ma;
        logic        coast_start;
    } sdr_state_t;

    localparam sdr_state_t ST_RESET = '{hready: 1'b1, wr_pend: 1'b0, wr_addr: 12'h000, rdata: 32'h0000_0000,
                                        startup: sdr_pkg::RST_STARTUP, reversal: sdr_pkg::RST_REVERSAL,
                                        standstill: 1'b0, handoff: 1'b0, ilimit_ma: 13'h0000,
                                        coast_start: 1'b0};

    sdr_state_t s_r;
    sdr_state_t s_nxt;
    logic       coast_busy;
    logic       addr_ok;

    // A transfer is taken only when selected, non-idle and the bus is ready.
    assign addr_ok = hsel && htrans[1] && hready;

    // ========================================================================
    // Next state: bus slave, register file and comparators
    // ========================================================================
    // The pending write lands first so a read in the next address phase sees it.
    always_comb begin
        s_nxt             = s_r;
        s_nxt.hready      = 1'b1;
        s_nxt.coast_start = 1'b0;
        if (s_r.wr_pend) begin
            s_nxt.wr_pend = 1'b0;
            case (s_r.wr_addr)
                sdr_pkg::ADDR_STARTUP:  s_nxt.startup  = hwdata;
                sdr_pkg::ADDR_REVERSAL: s_nxt.reversal = hwdata; // see RULE_04 see RULE_05
                default:                ;
            endcase
        end
        if (addr_ok) begin
            s_nxt.wr_pend = hwrite;
            s_nxt.wr_addr = haddr[11:0];
            if (!hwrite) begin
                case (haddr[11:0])
                    sdr_pkg::ADDR_STARTUP:  s_nxt.rdata = s_nxt.startup;
                    sdr_pkg::ADDR_REVERSAL: s_nxt.rdata = s_nxt.reversal;
                    sdr_pkg::ADDR_STATUS: begin
                        s_nxt.rdata                          = 32'h0000_0000;
                        s_nxt.rdata[sdr_pkg::STS_COAST]      = coast_busy;
                        s_nxt.rdata[sdr_pkg::STS_STANDSTILL] = s_r.standstill;
                        s_nxt.rdata[sdr_pkg::STS_HANDOFF]    = s_r.handoff;
                    end
                    default:                s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Standstill compares against the selected back-EMF level.
        s_nxt.standstill = bemf_mv < sdr_pkg::sdr_bemf_mv(
                           s_r.startup[sdr_pkg::SSD_BEMF_HI:sdr_pkg::SSD_BEMF_LO]); // see RULE_01
        // Hand-off needs reverse drive enabled and a decelerating reversal.
        s_nxt.handoff = s_r.startup[sdr_pkg::SSD_REV_ON] && reversal_decel // see RULE_07
                        && (speed_permille <= sdr_pkg::sdr_speed_pm(
                            s_r.startup[sdr_pkg::SSD_SPEED_HI:sdr_pkg::SSD_SPEED_LO])); // see RULE_02
        s_nxt.ilimit_ma = sdr_pkg::sdr_ilimit_ma(
                          s_r.startup[sdr_pkg::SSD_ILIM_HI:sdr_pkg::SSD_ILIM_LO]); // see RULE_03
        // A coast request is honoured only while the coast step is enabled.
        s_nxt.coast_start = coast_request && s_r.startup[sdr_pkg::SSD_COAST_ON]; // see RULE_08
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ========================================================================
    // Coast timer
    // ========================================================================
    // Clearing the enable aborts a coast in progress rather than letting it run out.
    sdr_coast_timer #(
        .TICK_CYCLES (MS_TICK_CYCLES)
    ) u_coast (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (s_r.coast_start),
        .abort   (!s_r.startup[sdr_pkg::SSD_COAST_ON]),
        .dur_ms  (sdr_pkg::sdr_coast_ms(s_r.startup[sdr_pkg::SSD_COAST_HI:sdr_pkg::SSD_COAST_LO])), // see RULE_06
        .active  (coast_busy)
    );

    // ========================================================================
    // Outputs, all taken from flip-flops except hresp, which is tied low
    // ========================================================================
    assign hreadyout                = s_r.hready;
    assign hresp                    = 1'b0;
    assign hrdata                   = s_r.rdata;
    assign motor_standstill         = s_r.standstill;
    assign open_loop_handoff        = s_r.handoff;
    assign reversal_openloop_ilimit = s_r.ilimit_ma;
    assign coast_active             = coast_busy;
    assign reversal_drive_on        = s_r.startup[sdr_pkg::SSD_REV_ON];
    assign coast_step_on            = s_r.startup[sdr_pkg::SSD_COAST_ON];
    assign reversal_ramp_coef_one   = s_r.reversal[sdr_pkg::RDS_COEF1_HI:sdr_pkg::RDS_COEF1_LO];
    assign reversal_ramp_coef_two   = s_r.reversal[sdr_pkg::RDS_COEF2_HI:sdr_pkg::RDS_COEF2_LO];
    assign braking_ilimit_sel       = s_r.reversal[sdr_pkg::RDS_BRKI_HI:sdr_pkg::RDS_BRKI_LO];
    assign braking_prop_gain        = s_r.reversal[sdr_pkg::RDS_KP_HI:sdr_pkg::RDS_KP_LO];
    assign braking_integ_gain       = s_r.reversal[sdr_pkg::RDS_KI_HI:sdr_pkg::RDS_KI_LO];
    assign reversal_parity          = s_r.reversal[sdr_pkg::RDS_PARITY];

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Address phase of a write to the reversal register, and of a read from it.
    sequence rev_wr_addr;
        addr_ok && hwrite && (haddr[11:0] == sdr_pkg::ADDR_REVERSAL);
    endsequence

    sequence rev_rd_addr;
        addr_ok && !hwrite && (haddr[11:0] == sdr_pkg::ADDR_REVERSAL);
    endsequence

    // A completed write is visible on the parity and first coefficient outputs one edge after its data phase.
    chk_rev_write_lands: assert property (rev_wr_addr ##1 1'b1 |=> // see RULE_04
        ({reversal_parity, reversal_ramp_coef_one} == $past(hwdata[31:27])))
        else $error("reversal write did not land");

    // A read right after a write returns the written word.
    chk_rev_readback: assert property (rev_wr_addr ##1 rev_rd_addr |=> // see RULE_05
        (hrdata == $past(hwdata)))
        else $error("reversal readback mismatch");

    chk_rev_field_map: assert property ({reversal_parity, reversal_ramp_coef_one, reversal_ramp_coef_two, // see RULE_05
        braking_ilimit_sel, braking_prop_gain, braking_integ_gain} == s_r.reversal)
        else $error("reversal field map wrong");

    chk_standstill_cmp: assert property (##1 (motor_standstill == // see RULE_01
        ($past(bemf_mv) < sdr_pkg::sdr_bemf_mv($past(s_r.startup[8:6])))))
        else $error("standstill compare wrong");

    chk_handoff_cmp: assert property (##1 (open_loop_handoff == // see RULE_02
        ($past(reversal_drive_on) && $past(reversal_decel)
         && ($past(speed_permille) <= sdr_pkg::sdr_speed_pm($past(s_r.startup[5:2]))))))
        else $error("handoff compare wrong");

    chk_ilimit_map: assert property ($stable(s_r.startup[1:0]) |=> // see RULE_03
        (reversal_openloop_ilimit == sdr_pkg::sdr_ilimit_ma($past(s_r.startup[1:0]))))
        else $error("reversal current limit wrong");

    chk_rev_gate: assert property (!reversal_drive_on |=> !open_loop_handoff) // see RULE_07
        else $error("handoff while reverse drive off");

    chk_coast_gate: assert property ($rose(coast_active) |-> // see RULE_08
        ($past(coast_step_on, 2) && $past(coast_request, 2)))
        else $error("coast began without enable and request");

    chk_coast_min_len: assert property ($rose(coast_active) && (MS_TICK_CYCLES > 8) |-> // see RULE_06
        coast_active [*8])
        else $error("coast ended too early");

    chk_coast_abort: assert property (!coast_step_on |=> !coast_active) // see RULE_08
        else $error("coast continued after disable");

endmodule : sdr_settings_bank

/* File: testbench/sdr_motor_model.sv */
// Purpose: Behavioural motor seen through the power stage: back-EMF and speed.
// Assumes: One clock; the bench sets the targets.
// Notes:   Values reach the bank one clock after a target changes.
`timescale 1ns/1ps
module sdr_motor_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [10:0] bemf_set,
    input  wire logic [9:0]  speed_set,
    output logic      [10:0] bemf_mv,
    output logic      [9:0]  speed_permille
);
    // ========================================================================
    // Sensor path
    // ========================================================================
    // Registered so the bank never sees a change in the edge that launched it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bemf_mv       <= 11'h7ff;
            speed_permille <= 10'h3ff;
        end else begin
            bemf_mv       <= bemf_set;
            speed_permille <= speed_set;
        end
    end
endmodule : sdr_motor_model

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the speed detect and reversal settings bank.
// Assumes: Zero-wait AHB-Lite slave; millisecond tick shortened to 10 cycles.
// Notes:   Coast lengths are counted over a fixed window longer than the longest code used.
`timescale 1ns/1ps
module tb_top;
    localparam int TICK = 10;
    localparam int BEMF_TAB[8]   = '{50, 75, 100, 250, 500, 750, 1000, 1500};
    localparam int SPEED_TAB[16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500, 600, 700, 800, 900, 1000};
    localparam int ILIM_TAB[4]   = '{1500, 2500, 3500, 5000};
    localparam int COAST_TAB[3]  = '{10, 50, 100};
    logic        hclk, hresetn, hsel, hwrite, hready_o, hresp, decel, coast_req;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [10:0] bemf_set, bemf;
    logic [9:0]  speed_set, speed, kp, ki;
    logic [12:0] ilim;
    logic [3:0]  c1, c2;
    logic [2:0]  bsel;
    logic        still, hand, coast, rev_on, coast_on, par;
    int          err_count, total_checks, i, k, cnt;

    sdr_motor_model motor (.hclk(hclk), .hresetn(hresetn), .bemf_set(bemf_set), .speed_set(speed_set),
        .bemf_mv(bemf), .speed_permille(speed));
    sdr_settings_bank #(.MS_TICK_CYCLES(TICK)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready_o), .hreadyout(hready_o), .hresp(hresp), .hrdata(hrdata), .bemf_mv(bemf),
        .speed_permille(speed), .reversal_decel(decel), .coast_request(coast_req),
        .motor_standstill(still), .open_loop_handoff(hand), .reversal_openloop_ilimit(ilim),
        .coast_active(coast), .reversal_drive_on(rev_on), .coast_step_on(coast_on),
        .reversal_ramp_coef_one(c1), .reversal_ramp_coef_two(c2), .braking_ilimit_sel(bsel),
        .braking_prop_gain(kp), .braking_integ_gain(ki), .reversal_parity(par));

    // ========================================================================
    // Clock
    // ========================================================================
    // Free-running 100 MHz clock.
    always #5 hclk = ~hclk;

    // ========================================================================
    // Tasks
    // ========================================================================
    // Prints the verdict; the single place where the run ends.
    task complete_run;
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait for hready; a stuck bus ends the run as a failure.
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready_o !== 1'b1 && n < 50);
        if (hready_o !== 1'b1) begin
            err_count++;
            complete_run();
        end
    endtask : wait_ready

    task bus(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    // The write lands at the edge that ends the data phase, so one more edge passes before
    // anyone samples a field output; reading in that same time step would race the update.
    task wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(a, 1'b1, v, x);
        @(posedge hclk);
    endtask : wr

    // Write whose data phase carries the address phase of a read to the same register.
    task wr_rd(input logic [11:0] a, input logic [31:0] v);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wait_ready();
        hwrite <= 1'b0;
        hwdata <= v;
        wait_ready();
        htrans <= 2'h0;
        wait_ready();
        chk(hrdata, v);
    endtask : wr_rd

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, x);
        chk(x, e);
    endtask : rdchk

    // Model register plus bank comparator make two edges of latency.
    task settle;
        repeat (3) @(posedge hclk);
    endtask : settle

    function automatic logic [31:0] exp_coast(input int c, input int en);
        return en ? COAST_TAB[c] * 1000 / 1000 * TICK : 0;
    endfunction : exp_coast

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
        hwdata = 0; bemf_set = 0; speed_set = 0; decel = 0; coast_req = 0;
        err_count = 0;
        total_checks = 0;
        i = $urandom(79);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(12'h208, 32'h0);
        rdchk(12'h200, 32'h0);
        chk({par, c1, c2, bsel, kp, ki}, 32'h0);
        // Corner patterns first, then random words, each back through fields and read-back.
        for (i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h8000_0001 : $urandom;
            wr_rd(12'h208, ~d);
            wr(12'h208, d);
            rdchk(12'h208, d);
            chk({par, c1, c2, bsel, kp, ki}, d);
        end
        wr(12'h204, 32'h5a5a_5a5a);
        rdchk(12'h204, 32'h0);
        // Back-EMF one below and at each level; current limit codes ride along.
        for (i = 0; i < 8; i++) begin
            wr(12'h200, (i << 6) | (i & 3));
            bemf_set <= 11'(BEMF_TAB[i] - 1);
            settle();
            chk(ilim, ILIM_TAB[i & 3]);
            chk(still, 1'b1);
            rdchk(12'h280, 32'h0000_0002);
            bemf_set <= 11'(BEMF_TAB[i]);
            settle();
            chk(still, 1'b0);
        end
        // Hand-off at and just above each threshold, random speed at or below on odd codes.
        decel <= 1'b1;
        for (i = 0; i < 16; i++) begin
            wr(12'h200, 32'h0800_0000 | (i << 2));
            chk(rev_on, 1'b1);
            speed_set <= (i % 2) ? 10'($urandom_range(SPEED_TAB[i])) : 10'(SPEED_TAB[i]);
            settle();
            chk(hand, 1'b1);
            speed_set <= 10'(SPEED_TAB[i] + 1);
            settle();
            chk(hand, 1'b0);
        end
        wr(12'h200, 32'h0000_003c);
        speed_set <= 10'h0;
        settle();
        chk(hand, 1'b0);
        // Coast lengths for three codes, then a request with the step disabled.
        for (k = 0; k < 4; k++) begin
            wr(12'h200, ((k < 3) << 28) | ((k % 3) << 9));
            chk(coast_on, k < 3);
            @(posedge hclk);
            coast_req <= 1'b1;
            @(posedge hclk);
            coast_req <= 1'b0;
            cnt = 0;
            repeat (1100) begin
                @(posedge hclk);
                if (coast === 1'b1)
                    cnt++;
            end
            chk(cnt, exp_coast(k % 3, k < 3));
        end
        complete_run();
    end
endmodule : tb_top
